/* mem_space_pkg.sv */
// shared constants for the core memory space decoder
// How it works
// - flash mapped contiguous 0x0000 to 0x3fff
// - program addresses above 0x3dff are reserved
// - program memory writable only with write enable
// - access type selects program or data space
// - 256 bytes internal data ram
// - lower 128 bytes direct and indirect
// - upper direct goes sfr, indirect goes ram
// - 0x00-0x1f are four banks of eight
// - status word bits 3,4 select bank
// - indirect pointer from register zero or one
// - bytes 0x20-0x2f bit addressable, 128 bits
// - bit operand means single bit access
// - push writes sp+1 then increments sp
// - reset loads stack pointer with 0x07
// - stack anywhere in ram, 256 deep
// - stack pointer at direct address 0x81
// - direct 0x80-0xff decode as sfr
// - sfr bit access only at x0/x8
// - bank value n selects base n*8
package mem_space_pkg;
  localparam logic [15:0] FLASH_BASE = 16'h0000;
  localparam logic [15:0] FLASH_TOP = 16'h3fff;
  localparam logic [15:0] PROG_RESV_ABOVE = 16'h3dff;
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] BIT_BYTE_BASE = 8'h20;
  localparam logic [7:0] BIT_BYTE_TOP = 8'h2f;
  localparam logic [7:0] ADDR_STACK_POINTER = 8'h81;
  localparam logic [7:0] ADDR_DATA_POINTER_LOW = 8'h82;
  localparam logic [7:0] ADDR_DATA_POINTER_HIGH = 8'h83;
  localparam logic [7:0] ADDR_PROGRAM_STORE_CONTROL = 8'h8f;
  localparam logic [7:0] ADDR_PROGRAM_STATUS_WORD = 8'hd0;
  localparam logic [7:0] ADDR_PRIMARY_WORKING_REGISTER = 8'he0;
  localparam logic [7:0] ADDR_SECOND_OPERAND_REG = 8'hf0;
  localparam logic [7:0] RST_STACK_POINTER = 8'h07;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam int PROGRAM_WRITE_ENABLE_BIT = 0;
  localparam int BANK_SELECT_LOW_BIT = 3;
  localparam int BANK_SELECT_HIGH_BIT = 4;
  typedef enum logic [2:0] {
    ACC_DIRECT, ACC_INDIRECT, ACC_BIT, ACC_CODE, ACC_EXT_MOVE, ACC_PUSH, ACC_POP, ACC_REG
  } access_kind_t;
endpackage

/* data_ram.sv */
// 256 byte internal data ram, one read and one write port
`timescale 1ns/1ps
`default_nettype none
module data_ram #(
  parameter int DEPTH = 256
) (
  input wire logic clk_sys_i,
  input wire logic we_i,
  input wire logic [7:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] raddr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem_r [DEPTH];
  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end
  assign rdata_o = mem_r[raddr_i];
endmodule
`default_nettype wire

/* program_mem.sv */
// program memory array, write only when the core enables it
`timescale 1ns/1ps
`default_nettype none
module program_mem #(
  parameter int AW = 14
) (
  input wire logic clk_sys_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem_r [2**AW];
  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem_r[addr_i] <= wdata_i;
    end
  end
  assign rdata_o = mem_r[addr_i];
endmodule
`default_nettype wire

/* core_memory_space_decoder.sv */
// memory space decoder: program, data ram, register banks, bits, stack and sfrs
`timescale 1ns/1ps
`default_nettype none
module core_memory_space_decoder
  import mem_space_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic wr_i,
  input wire access_kind_t kind_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic ack_o,
  output logic bit_o,
  output logic sfr_hit_o,
  output logic reserved_o,
  output logic [7:0] stack_pointer_o,
  output logic [1:0] bank_o,
  output logic program_write_enable_o
);
  logic [7:0] stack_pointer_r;
  logic [7:0] data_pointer_low_r;
  logic [7:0] data_pointer_high_r;
  logic [7:0] program_store_control_r;
  logic [7:0] program_status_word_r;
  logic [7:0] primary_working_register_r;
  logic [7:0] second_operand_reg_r;
  logic [7:0] rdata_r;
  logic ack_r;
  logic bit_r;
  logic sfr_hit_r;
  logic reserved_r;

  logic [1:0] bank;
  logic [7:0] ram_rdata;
  logic [7:0] ram_raddr;
  logic [7:0] ram_waddr;
  logic [7:0] ram_wdata;
  logic ram_we;
  logic [7:0] prog_rdata;
  logic prog_we;
  logic [7:0] a8;
  logic is_sfr;
  logic is_bit;
  logic [7:0] bit_byte;
  logic [2:0] bit_pos;
  logic [7:0] sfr_rdata;
  logic sfr_known;
  logic [7:0] stack_pointer_nxt;
  logic [7:0] wbyte;
  logic [7:0] cur_byte;

  assign a8 = addr_i[7:0];

  assign bank = {program_status_word_r[BANK_SELECT_HIGH_BIT], program_status_word_r[BANK_SELECT_LOW_BIT]};

  assign is_bit = (kind_i == ACC_BIT);

  assign is_sfr = (kind_i == ACC_DIRECT && a8 >= SFR_BASE) || (is_bit && a8[7]);

  always_comb begin
    bit_pos = a8[2:0];
    if (a8[7]) begin
      bit_byte = {a8[7:3], 3'h0};
    end else begin
      bit_byte = BIT_BYTE_BASE + {4'h0, a8[6:3]};
    end
  end

  // sfr read mux
  always_comb begin
    sfr_known = 1'b1;
    case (is_bit ? bit_byte : a8)
      ADDR_STACK_POINTER: sfr_rdata = stack_pointer_r;
      ADDR_DATA_POINTER_LOW: sfr_rdata = data_pointer_low_r;
      ADDR_DATA_POINTER_HIGH: sfr_rdata = data_pointer_high_r;
      ADDR_PROGRAM_STORE_CONTROL: sfr_rdata = program_store_control_r;
      ADDR_PROGRAM_STATUS_WORD: sfr_rdata = program_status_word_r;
      ADDR_PRIMARY_WORKING_REGISTER: sfr_rdata = primary_working_register_r;
      ADDR_SECOND_OPERAND_REG: sfr_rdata = second_operand_reg_r;
      default: begin
        // unoccupied: reads zero, writes dropped
        sfr_rdata = RST_ZERO;
        sfr_known = 1'b0;
      end
    endcase
  end

  // ram address selection per access kind
  always_comb begin
    ram_raddr = a8;
    case (kind_i)
      ACC_REG: ram_raddr = {3'h0, bank, a8[2:0]};
      ACC_INDIRECT: ram_raddr = {3'h0, bank, 2'h0, a8[0]};
      ACC_BIT: ram_raddr = bit_byte;
      ACC_PUSH: ram_raddr = stack_pointer_r + 8'h01;
      ACC_POP: ram_raddr = stack_pointer_r;
      default: ram_raddr = a8;
    endcase
  end

  // indirect access is two step: pointer fetched, then target; here the pointer
  // value itself is the final address, so a second ram port is avoided by a
  // registered pointer phase
  logic ind_phase_r;
  logic [7:0] ind_ptr_r;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ind_phase_r <= 1'b0;
      ind_ptr_r <= RST_ZERO;
    end else if (req_i && kind_i == ACC_INDIRECT && !ind_phase_r) begin
      ind_phase_r <= 1'b1;
      ind_ptr_r <= ram_rdata;
    end else begin
      ind_phase_r <= 1'b0;
    end
  end

  logic [7:0] ram_addr_final;
  assign ram_addr_final = ind_phase_r ? ind_ptr_r : ram_raddr;

  assign cur_byte = is_sfr ? sfr_rdata : ram_rdata;

  always_comb begin
    wbyte = wdata_i;
    if (is_bit) begin
      wbyte = cur_byte;
      wbyte[bit_pos] = wdata_i[0];
    end
  end

  logic step_done;
  assign step_done = req_i && !(kind_i == ACC_INDIRECT && !ind_phase_r);

  assign ram_we = step_done && !is_sfr &&
    ((wr_i && (kind_i == ACC_DIRECT || kind_i == ACC_INDIRECT || kind_i == ACC_BIT || kind_i == ACC_REG))
     || kind_i == ACC_PUSH);
  assign ram_waddr = ram_addr_final;
  assign ram_wdata = wbyte;

  data_ram #(.DEPTH(256)) u_ram (
    .clk_sys_i(clk_sys_i),
    .we_i(ram_we),
    .waddr_i(ram_waddr),
    .wdata_i(ram_wdata),
    .raddr_i(ram_addr_final),
    .rdata_o(ram_rdata)
  );

  assign prog_we = req_i && wr_i && kind_i == ACC_EXT_MOVE &&
    program_store_control_r[PROGRAM_WRITE_ENABLE_BIT] && addr_i <= FLASH_TOP;

  program_mem #(.AW(14)) u_prog (
    .clk_sys_i(clk_sys_i),
    .we_i(prog_we),
    .addr_i(addr_i[13:0]),
    .wdata_i(wdata_i),
    .rdata_o(prog_rdata)
  );

  logic sfr_we;
  assign sfr_we = req_i && is_sfr && sfr_known && (wr_i || kind_i == ACC_POP) && kind_i != ACC_POP;

  always_comb begin
    stack_pointer_nxt = stack_pointer_r;
    if (req_i && kind_i == ACC_PUSH) begin
      stack_pointer_nxt = stack_pointer_r + 8'h01;
    end else if (req_i && kind_i == ACC_POP) begin
      stack_pointer_nxt = stack_pointer_r - 8'h01;
    end else if (sfr_we && (is_bit ? bit_byte : a8) == ADDR_STACK_POINTER) begin
      stack_pointer_nxt = wbyte;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      stack_pointer_r <= RST_STACK_POINTER;
    end else begin
      stack_pointer_r <= stack_pointer_nxt;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      data_pointer_low_r <= RST_ZERO;
      data_pointer_high_r <= RST_ZERO;
      program_store_control_r <= RST_ZERO;
      program_status_word_r <= RST_ZERO;
      primary_working_register_r <= RST_ZERO;
      second_operand_reg_r <= RST_ZERO;
    end else if (sfr_we) begin
      case (is_bit ? bit_byte : a8)
        ADDR_DATA_POINTER_LOW: data_pointer_low_r <= wbyte;
        ADDR_DATA_POINTER_HIGH: data_pointer_high_r <= wbyte;
        ADDR_PROGRAM_STORE_CONTROL: program_store_control_r <= wbyte;
        ADDR_PROGRAM_STATUS_WORD: program_status_word_r <= wbyte;
        ADDR_PRIMARY_WORKING_REGISTER: primary_working_register_r <= wbyte;
        ADDR_SECOND_OPERAND_REG: second_operand_reg_r <= wbyte;
        default: ;
      endcase
    end
  end

  // answer registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rdata_r <= RST_ZERO;
      ack_r <= 1'b0;
      bit_r <= 1'b0;
      sfr_hit_r <= 1'b0;
      reserved_r <= 1'b0;
    end else begin
      ack_r <= step_done;
      bit_r <= step_done && is_bit;
      sfr_hit_r <= step_done && is_sfr;
      reserved_r <= step_done && (kind_i == ACC_CODE || kind_i == ACC_EXT_MOVE) && addr_i > PROG_RESV_ABOVE;
      if (step_done) begin
        if (kind_i == ACC_CODE || kind_i == ACC_EXT_MOVE) begin
          rdata_r <= (addr_i <= FLASH_TOP) ? prog_rdata : RST_ZERO;
        end else if (is_bit) begin
          rdata_r <= {7'h00, cur_byte[bit_pos]};
        end else begin
          rdata_r <= cur_byte;
        end
      end
    end
  end

  assign rdata_o = rdata_r;
  assign ack_o = ack_r;
  assign bit_o = bit_r;
  assign sfr_hit_o = sfr_hit_r;
  assign reserved_o = reserved_r;
  assign stack_pointer_o = stack_pointer_r;
  assign bank_o = program_status_word_r[BANK_SELECT_HIGH_BIT:BANK_SELECT_LOW_BIT];
  assign program_write_enable_o = program_store_control_r[PROGRAM_WRITE_ENABLE_BIT];

  property p_sp_reset;
    @(posedge clk_sys_i) !rst_n_i |=> stack_pointer_o == RST_STACK_POINTER;
  endproperty
  a_sp_reset: assert property (p_sp_reset) else $error("sp not 0x07 after reset");

  property p_push_inc;
    @(posedge clk_sys_i) disable iff (!rst_n_i) req_i && kind_i == ACC_PUSH |=> stack_pointer_o == $past(stack_pointer_o) + 8'h01;
  endproperty
  a_push_inc: assert property (p_push_inc) else $error("push did not increment sp");

  property p_prog_ro;
    @(posedge clk_sys_i) disable iff (!rst_n_i) req_i && wr_i && kind_i == ACC_EXT_MOVE && !program_write_enable_o
      |=> u_prog.mem_r[$past(addr_i[13:0])] == $past(prog_rdata);
  endproperty
  a_prog_ro: assert property (p_prog_ro) else $error("program written without enable");

  property p_sfr_dec;
    @(posedge clk_sys_i) disable iff (!rst_n_i) req_i && kind_i == ACC_DIRECT && addr_i[7] |=> sfr_hit_o && ack_o;
  endproperty
  a_sfr_dec: assert property (p_sfr_dec) else $error("direct upper not sfr");

  property p_ind_ram;
    @(posedge clk_sys_i) disable iff (!rst_n_i) req_i && kind_i == ACC_INDIRECT && ind_phase_r |=> ack_o && !sfr_hit_o;
  endproperty
  a_ind_ram: assert property (p_ind_ram) else $error("indirect reached sfr");

  property p_bank;
    @(posedge clk_sys_i) disable iff (!rst_n_i) req_i && kind_i == ACC_REG |-> ram_raddr[7:3] == {3'h0, bank_o};
  endproperty
  a_bank: assert property (p_bank) else $error("bank base wrong");

  property p_bitmap;
    @(posedge clk_sys_i) disable iff (!rst_n_i) is_bit && !a8[7] |->
      bit_byte >= BIT_BYTE_BASE && bit_byte <= BIT_BYTE_TOP && {bit_byte[3:0], bit_pos} == a8[6:0];
  endproperty
  a_bitmap: assert property (p_bitmap) else $error("bit address map wrong");

  property p_resv;
    @(posedge clk_sys_i) disable iff (!rst_n_i) req_i && kind_i == ACC_CODE && addr_i > PROG_RESV_ABOVE |=> reserved_o;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved not flagged");
endmodule
`default_nettype wire

/* core_exec_model.sv */
// execution unit model issuing one memory access at a time
`timescale 1ns/1ps
`default_nettype none
module core_exec_model
  import mem_space_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic ack_i,
  input wire logic [7:0] rdata_i,
  input wire logic [2:0] flags_i,
  output logic req_o,
  output logic wr_o,
  output access_kind_t kind_o,
  output logic [15:0] addr_o,
  output logic [7:0] wdata_o
);
  logic [7:0] rd;
  logic [2:0] fl;
  int lat;
  initial begin
    req_o = 1'b0;
    wr_o = 1'b0;
    kind_o = ACC_DIRECT;
    addr_o = 16'h0000;
    wdata_o = 8'h00;
  end
  task automatic access(input access_kind_t k, input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    req_o <= 1'b1;
    wr_o <= w;
    kind_o <= k;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_sys_i);
    if (k == ACC_INDIRECT) begin
      @(posedge clk_sys_i);
    end
    req_o <= 1'b0;
    // inverted after release so a stale value cannot pass
    addr_o <= ~a;
    wdata_o <= ~d;
    lat = -1;
    for (int i = 0; i < 4 && lat < 0; i++) begin
      @(negedge clk_sys_i);
      if (ack_i === 1'b1) begin
        lat = i;
        rd = rdata_i;
        fl = flags_i;
      end
    end
  endtask
endmodule
`default_nettype wire

/* core_memory_space_decoder_tb_top.sv */
// self-checking bench for the core memory space decoder
`timescale 1ns/1ps
`default_nettype none
module core_memory_space_decoder_tb_top
  import mem_space_pkg::*;
();
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req, wr, ack, bit_f, sfr_f, res_f, pwe;
  access_kind_t kind;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, sp;
  logic [1:0] bank;
  int n_mismatch = 0;
  int checks_done = 0;
  initial begin
    forever #20 clk = ~clk;
  end
  core_memory_space_decoder u_dut (.clk_sys_i(clk), .rst_n_i(rst_n), .req_i(req), .wr_i(wr), .kind_i(kind),
    .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .ack_o(ack), .bit_o(bit_f), .sfr_hit_o(sfr_f),
    .reserved_o(res_f), .stack_pointer_o(sp), .bank_o(bank), .program_write_enable_o(pwe));
  core_exec_model u_core (.clk_sys_i(clk), .ack_i(ack), .rdata_i(rdata), .flags_i({bit_f, sfr_f, res_f}),
    .req_o(req), .wr_o(wr), .kind_o(kind), .addr_o(addr), .wdata_o(wdata));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic acc(input access_kind_t k, input logic w, input logic [15:0] a, input logic [7:0] d);
    u_core.access(k, w, a, d);
    chk("latency", 8'h00, 8'(u_core.lat));
    if (u_core.lat < 0) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  task automatic wd(input logic [7:0] a, input logic [7:0] d);
    acc(ACC_DIRECT, 1'b1, {8'h00, a}, d);
  endtask
  task automatic rdd(input access_kind_t k, input logic [15:0] a, input logic [7:0] exp, input logic [2:0] fl);
    acc(k, 1'b0, a, 8'h00);
    chk("rdata", exp, u_core.rd);
    chk("flags", {5'h00, fl}, {5'h00, u_core.fl});
  endtask
  task automatic t_reset();
    chk("sp", 8'h07, sp);
    chk("bank", 8'h00, {6'h00, bank});
    chk("pwe", 8'h00, {7'h00, pwe});
    rdd(ACC_DIRECT, 16'h0081, 8'h07, 3'b010);
    $display("reset test done");
  endtask
  task automatic t_stack();
    acc(ACC_PUSH, 1'b1, 16'h0000, 8'ha5);
    chk("sp", 8'h08, sp);
    rdd(ACC_DIRECT, 16'h0008, 8'ha5, 3'b000);
    rdd(ACC_POP, 16'h0000, 8'ha5, 3'b000);
    chk("sp", 8'h07, sp);
    wd(8'h81, 8'hfe);
    acc(ACC_PUSH, 1'b1, 16'h0000, 8'h66);
    chk("sp", 8'hff, sp);
    acc(ACC_REG, 1'b1, 16'h0000, 8'hff);
    rdd(ACC_INDIRECT, 16'h0000, 8'h66, 3'b000);
    wd(8'h81, 8'h07);
    $display("stack test done");
  endtask
  task automatic t_banks();
    for (int n = 0; n < 4; n++) begin
      wd(8'hd0, 8'(n << 3));
      chk("bank", 8'(n), {6'h00, bank});
      acc(ACC_REG, 1'b1, 16'h0005, 8'(8'h50 + n));
      rdd(ACC_DIRECT, 16'(n * 8 + 5), 8'(8'h50 + n), 3'b000);
    end
    wd(8'hd0, 8'h00);
    $display("bank test done");
  endtask
  task automatic t_split();
    wd(8'hf0, 8'h3c);
    acc(ACC_REG, 1'b1, 16'h0000, 8'hf0);
    acc(ACC_REG, 1'b1, 16'h0001, 8'h40);
    acc(ACC_INDIRECT, 1'b1, 16'h0000, 8'h77);
    acc(ACC_INDIRECT, 1'b1, 16'h0001, 8'h9a);
    rdd(ACC_DIRECT, 16'h00f0, 8'h3c, 3'b010);
    rdd(ACC_INDIRECT, 16'h0000, 8'h77, 3'b000);
    rdd(ACC_DIRECT, 16'h0040, 8'h9a, 3'b000);
    $display("split test done");
  endtask
  task automatic t_bits();
    wd(8'h22, 8'h00);
    wd(8'h2f, 8'h00);
    acc(ACC_BIT, 1'b1, 16'h0013, 8'h01);
    acc(ACC_BIT, 1'b1, 16'h007f, 8'h01);
    rdd(ACC_DIRECT, 16'h0022, 8'h08, 3'b000);
    rdd(ACC_DIRECT, 16'h002f, 8'h80, 3'b000);
    rdd(ACC_BIT, 16'h0013, 8'h01, 3'b100);
    acc(ACC_BIT, 1'b1, 16'h00f0, 8'h01);
    rdd(ACC_DIRECT, 16'h00f0, 8'h3d, 3'b010);
    rdd(ACC_BIT, 16'h00f2, 8'h01, 3'b110);
    $display("bit test done");
  endtask
  task automatic t_prog();
    wd(8'h8f, 8'h01);
    chk("pwe", 8'h01, {7'h00, pwe});
    acc(ACC_EXT_MOVE, 1'b1, 16'h0040, 8'hc3);
    wd(8'h8f, 8'h00);
    // a write with the enable off must leave the byte alone
    acc(ACC_EXT_MOVE, 1'b1, 16'h0040, 8'h11);
    rdd(ACC_CODE, 16'h0040, 8'hc3, 3'b000);
    rdd(ACC_DIRECT, 16'h0040, 8'h9a, 3'b000);
    acc(ACC_CODE, 1'b0, 16'h3dff, 8'h00);
    chk("reserved", 8'h00, {5'h00, u_core.fl});
    acc(ACC_CODE, 1'b0, 16'h3e00, 8'h00);
    chk("reserved", 8'h01, {5'h00, u_core.fl});
    rdd(ACC_CODE, 16'h4000, 8'h00, 3'b001);
    $display("program test done");
  endtask
  task automatic t_rerun();
    wd(8'h81, 8'h30);
    wd(8'h8f, 8'h01);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk("sp", 8'h07, sp);
    chk("pwe", 8'h00, {7'h00, pwe});
    rdd(ACC_DIRECT, 16'h0081, 8'h07, 3'b010);
    $display("rerun test done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_stack();
    t_banks();
    t_split();
    t_bits();
    t_prog();
    t_rerun();
    stop_test();
  end
endmodule
`default_nettype wire
